// [rtl/ccr_charger_config_regs.sv]
`timescale 1ns/100ps
// How it works
// - Plug-in restores high-impedance bit default.
// - Offset 0 bit 7 selects high-impedance mode.
// - Status pin on at 00, off at 11.
// - Input limit 100 mA plus 100 mA steps.
// - Offset 1 bit 7 disables pulse-frequency mode.
// - Reverse boost enable, cleared by watchdog.
// - Charge enable, default one, watchdog restores.
// - Fast-charge current in 60 mA steps.
// - Fast-charge code zero stops charging.
// - Codes above 110010 clamp to 110010.
// - Precharge 60 mA offset, 60 mA steps.
// - Precharge spans 60-960 mA, default 0010.
// - Charge voltage 3.848 V plus 32 mV steps.
// - Charge voltage default code 01011, 4.2 V.
// - Separate fine-trim field adjusts charge voltage.
module ccr_charger_config_regs
	import ccr_pkg::*;
#(
	// Charge voltage change per fine-trim code, in millivolts.
	parameter logic [12:0] CV_TRIM_STEP_MV = 13'h0008
)
(
	// Clock and reset.
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// Register access port from the serial target.
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	output logic O_REG_ACK,
	// Reset events from the rest of the charger.
	input wire logic I_REG_RESET,
	input wire logic I_WDT_EXPIRED,
	input wire logic I_INPUT_PLUGIN,
	// Fine trim of the charge voltage from another register.
	input wire logic [1:0] I_CHARGE_VOLTAGE_TRIM,
	// Settings and events toward the charger core.
	output ccr_cfg_t O_CFG,
	output logic O_WATCHDOG_KICK
);

	// Stored register bits, one byte per offset.
	logic [7:0] regs_ff [0:NUM_REGS-1];
	logic [7:0] nxt_regs [0:NUM_REGS-1];
	// Watchdog kick stays set for exactly one cycle after the write.
	logic kick_ff;
	logic nxt_kick;
	// Read data is held until the next read.
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	// Registered settings toward the core.
	ccr_cfg_t cfg_ff;
	ccr_cfg_t nxt_cfg;
	// Address is inside the implemented bank.
	logic addr_hit;
	// Helpers for the decoded settings.
	logic [5:0] icc_code;
	logic [5:0] icc_eff;
	logic [4:0] vreg_code;

	// Constant tables indexed by offset.
	localparam logic [7:0] RST_VAL [0:NUM_REGS-1] = '{RST_INPUT_CONTROL, RST_OPERATION_CONTROL,
		RST_FAST_CHARGE_CURRENT, RST_PRECHARGE_TERMINATION, RST_CHARGE_VOLTAGE_CONTROL};
	localparam logic [7:0] WMASK [0:NUM_REGS-1] = '{WMASK_INPUT_CONTROL, WMASK_OPERATION_CONTROL,
		WMASK_FAST_CHARGE_CURRENT, WMASK_PRECHARGE_TERMINATION, WMASK_CHARGE_VOLTAGE_CONTROL};
	localparam logic [7:0] WDMASK [0:NUM_REGS-1] = '{WDMASK_INPUT_CONTROL, WDMASK_OPERATION_CONTROL,
		WDMASK_FAST_CHARGE_CURRENT, WDMASK_PRECHARGE_TERMINATION, WDMASK_CHARGE_VOLTAGE_CONTROL};

	// Offsets above the bank are refused so the serial target can answer with a not-acknowledge.
	assign addr_hit = (I_REG_ADDR <= ADDR_LAST);

	// The acknowledge is combinational so the serial target can drive its answer in the same cycle.
	assign O_REG_ACK = (I_REG_WR | I_REG_RD) & addr_hit;

	// Next register values: a write first, then watchdog and plug-in masks, then a full register reset.
	// Reset events win over a write in the same cycle, since a reset must never be undone by a late write.
	always_comb
	begin
		nxt_kick = 1'b0;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			nxt_regs[i] = regs_ff[i];
			// Only writable bits take the new value; the rest keep their state.
			if (I_REG_WR && addr_hit && (I_REG_ADDR == 8'(i)))
			begin
				nxt_regs[i] = (I_REG_WDATA & WMASK[i]) | (regs_ff[i] & ~WMASK[i]);
			end
			// Watchdog expiry returns only the fields that it owns.
			if (I_WDT_EXPIRED)
			begin
				nxt_regs[i] = (nxt_regs[i] & ~WDMASK[i]) | (RST_VAL[i] & WDMASK[i]);
			end
		end
		// A new input source drops the part out of high-impedance mode.
		if (I_INPUT_PLUGIN)
		begin
			nxt_regs[0] = (nxt_regs[0] & ~PLUGMASK_INPUT_CONTROL)
				| (RST_INPUT_CONTROL & PLUGMASK_INPUT_CONTROL);
		end
		// Writing one to the kick bit raises it for a single cycle.
		if (I_REG_WR && (I_REG_ADDR == ADDR_OPERATION_CONTROL) && I_REG_WDATA[POS_KICK])
		begin
			nxt_kick = 1'b1;
		end
		// The register reset restores every field and cancels a pending kick.
		if (I_REG_RESET)
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				nxt_regs[i] = RST_VAL[i];
			end
			nxt_kick = 1'b0;
		end
	end

	// Read mux: the kick bit is shown from its own flop, the reserved bit reads zero.
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (I_REG_RD)
		begin
			case (I_REG_ADDR)
				ADDR_INPUT_CONTROL: nxt_rdata = regs_ff[0];
				ADDR_OPERATION_CONTROL: nxt_rdata = regs_ff[1] | {1'b0, kick_ff, 6'h00};
				ADDR_FAST_CHARGE_CURRENT: nxt_rdata = regs_ff[2];
				ADDR_PRECHARGE_TERMINATION: nxt_rdata = regs_ff[3];
				ADDR_CHARGE_VOLTAGE_CONTROL: nxt_rdata = regs_ff[4];
				// Unmapped offsets read as zero.
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Decoded settings, computed from the next register values so they line up with the registers.
	always_comb
	begin
		icc_code = nxt_regs[2][POS_ICC_MSB:0];
		// Codes past the top of the range behave as the top code.
		icc_eff = (icc_code > ICC_MAX_CODE) ? ICC_MAX_CODE : icc_code;
		vreg_code = nxt_regs[4][POS_VREG_MSB:POS_VREG_LSB];
		nxt_cfg = '0;
		// Input control fields.
		nxt_cfg.hiz_enable = nxt_regs[0][POS_HIZ];
		// The pin works only at code 00; code 11 and both reserved codes leave it off.
		nxt_cfg.status_pin_enable = (nxt_regs[0][POS_STAT_MSB:POS_STAT_LSB] == STAT_PIN_ON);
		nxt_cfg.input_current_limit = nxt_regs[0][POS_ICL_MSB:0];
		nxt_cfg.input_current_limit_ma = ICL_OFFSET_MA
			+ 12'(ICL_STEP_MA * 12'(nxt_regs[0][POS_ICL_MSB:0]));
		// Operation control fields.
		nxt_cfg.pulse_frequency_disable = nxt_regs[1][POS_PULSE_FREQUENCY_DISABLE];
		nxt_cfg.reverse_boost_enable = nxt_regs[1][POS_BOOST_EN];
		nxt_cfg.charge_enable_bit = nxt_regs[1][POS_CHG_EN];
		// A zero current code stops charging even with the enable bit set.
		nxt_cfg.charging_active = nxt_regs[1][POS_CHG_EN] && (icc_eff != 6'h00);
		nxt_cfg.minimum_system_voltage = nxt_regs[1][POS_VSYS_MSB:POS_VSYS_LSB];
		nxt_cfg.boost_battery_low_threshold = nxt_regs[1][POS_BOOST_LOW];
		// Fast-charge current.
		nxt_cfg.boost_current_limit = nxt_regs[2][POS_BOOST_CURRENT_LIMIT];
		nxt_cfg.fast_charge_current = icc_eff;
		nxt_cfg.fast_charge_current_ma = 12'(ICC_STEP_MA * 12'(icc_eff));
		// Precharge and termination share one encoding.
		nxt_cfg.precharge_current = nxt_regs[3][POS_PRE_MSB:POS_PRE_LSB];
		nxt_cfg.precharge_current_ma = PRE_OFFSET_MA
			+ 10'(PRE_STEP_MA * 10'(nxt_regs[3][POS_PRE_MSB:POS_PRE_LSB]));
		nxt_cfg.termination_current = nxt_regs[3][POS_TERM_MSB:0];
		nxt_cfg.termination_current_ma = PRE_OFFSET_MA
			+ 10'(PRE_STEP_MA * 10'(nxt_regs[3][POS_TERM_MSB:0]));
		// Charge voltage with its fine trim added on top.
		nxt_cfg.charge_voltage_code = vreg_code;
		nxt_cfg.charge_voltage_mv = VREG_OFFSET_MV + 13'(VREG_STEP_MV * 13'(vreg_code))
			+ 13'(CV_TRIM_STEP_MV * 13'(I_CHARGE_VOLTAGE_TRIM));
		// Top-off timer and recharge offset.
		nxt_cfg.top_off_timer = nxt_regs[4][POS_TOPOFF_MSB:POS_TOPOFF_LSB];
		nxt_cfg.top_off_minutes = 6'(TOPOFF_STEP_MIN * 6'(nxt_regs[4][POS_TOPOFF_MSB:POS_TOPOFF_LSB]));
		nxt_cfg.recharge_offset_mv = nxt_regs[4][POS_RECHG] ? RECHG_HIGH_MV : RECHG_LOW_MV;
	end

	// Power-on reset settings, used for the asynchronous reset of the settings flops.
	localparam ccr_cfg_t CFG_POR = '{
		hiz_enable: 1'b0,
		status_pin_enable: 1'b1,
		input_current_limit: 5'h04,
		input_current_limit_ma: 12'h1F4,
		pulse_frequency_disable: 1'b0,
		reverse_boost_enable: 1'b0,
		charge_enable_bit: 1'b1,
		charging_active: 1'b1,
		minimum_system_voltage: 3'h5,
		boost_battery_low_threshold: 1'b0,
		boost_current_limit: 1'b1,
		fast_charge_current: 6'h22,
		fast_charge_current_ma: 12'h7F8,
		precharge_current: 4'h2,
		precharge_current_ma: 10'h0B4,
		termination_current: 4'h2,
		termination_current_ma: 10'h0B4,
		charge_voltage_code: 5'h0B,
		charge_voltage_mv: 13'h1068,
		top_off_timer: 2'h0,
		top_off_minutes: 6'h00,
		recharge_offset_mv: 8'h64
	};

	// State registers only; all decisions are made above.
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				regs_ff[i] <= RST_VAL[i];
			end
			kick_ff <= 1'b0;
			rdata_ff <= 8'h00;
			cfg_ff <= CFG_POR;
		end
		else
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				regs_ff[i] <= nxt_regs[i];
			end
			kick_ff <= nxt_kick;
			rdata_ff <= nxt_rdata;
			cfg_ff <= nxt_cfg;
		end
	end

	// Outputs come straight from flops.
	assign O_REG_RDATA = rdata_ff;
	assign O_CFG = cfg_ff;
	assign O_WATCHDOG_KICK = kick_ff;

endmodule

// [rtl/ccr_pkg.sv]
package ccr_pkg;

	// Register offsets of the configuration bank.
	localparam logic [7:0] ADDR_INPUT_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_OPERATION_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_FAST_CHARGE_CURRENT = 8'h02;
	localparam logic [7:0] ADDR_PRECHARGE_TERMINATION = 8'h03;
	localparam logic [7:0] ADDR_CHARGE_VOLTAGE_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_LAST = 8'h04;
	localparam int NUM_REGS = 5;

	// Power-on values; the reserved bit of offset 0x02 reads as zero.
	localparam logic [7:0] RST_INPUT_CONTROL = 8'h04;
	localparam logic [7:0] RST_OPERATION_CONTROL = 8'h1A;
	localparam logic [7:0] RST_FAST_CHARGE_CURRENT = 8'hA2;
	localparam logic [7:0] RST_PRECHARGE_TERMINATION = 8'h22;
	localparam logic [7:0] RST_CHARGE_VOLTAGE_CONTROL = 8'h58;

	// Bits that software may store; the kick bit and the reserved bit are not stored.
	localparam logic [7:0] WMASK_INPUT_CONTROL = 8'hFF;
	localparam logic [7:0] WMASK_OPERATION_CONTROL = 8'hBF;
	localparam logic [7:0] WMASK_FAST_CHARGE_CURRENT = 8'hBF;
	localparam logic [7:0] WMASK_PRECHARGE_TERMINATION = 8'hFF;
	localparam logic [7:0] WMASK_CHARGE_VOLTAGE_CONTROL = 8'hFF;

	// Bits returned to their power-on value by a watchdog expiry.
	localparam logic [7:0] WDMASK_INPUT_CONTROL = 8'h80;
	localparam logic [7:0] WDMASK_OPERATION_CONTROL = 8'h70;
	localparam logic [7:0] WDMASK_FAST_CHARGE_CURRENT = 8'hBF;
	localparam logic [7:0] WDMASK_PRECHARGE_TERMINATION = 8'hFF;
	localparam logic [7:0] WDMASK_CHARGE_VOLTAGE_CONTROL = 8'hFE;

	// Bits returned to their power-on value when input power is plugged in.
	localparam logic [7:0] PLUGMASK_INPUT_CONTROL = 8'h80;

	// Field positions.
	localparam int POS_HIZ = 7;
	localparam int POS_STAT_MSB = 6;
	localparam int POS_STAT_LSB = 5;
	localparam int POS_ICL_MSB = 4;
	localparam int POS_PULSE_FREQUENCY_DISABLE = 7;
	localparam int POS_KICK = 6;
	localparam int POS_BOOST_EN = 5;
	localparam int POS_CHG_EN = 4;
	localparam int POS_VSYS_MSB = 3;
	localparam int POS_VSYS_LSB = 1;
	localparam int POS_BOOST_LOW = 0;
	localparam int POS_BOOST_CURRENT_LIMIT = 7;
	localparam int POS_ICC_MSB = 5;
	localparam int POS_PRE_MSB = 7;
	localparam int POS_PRE_LSB = 4;
	localparam int POS_TERM_MSB = 3;
	localparam int POS_VREG_MSB = 7;
	localparam int POS_VREG_LSB = 3;
	localparam int POS_TOPOFF_MSB = 2;
	localparam int POS_TOPOFF_LSB = 1;
	localparam int POS_RECHG = 0;

	// Encodings and scale factors.
	localparam logic [1:0] STAT_PIN_ON = 2'h0;
	localparam logic [1:0] STAT_PIN_OFF = 2'h3;
	localparam logic [11:0] ICL_OFFSET_MA = 12'h064;
	localparam logic [11:0] ICL_STEP_MA = 12'h064;
	localparam logic [5:0] ICC_MAX_CODE = 6'h32;
	localparam logic [11:0] ICC_STEP_MA = 12'h03C;
	localparam logic [9:0] PRE_OFFSET_MA = 10'h03C;
	localparam logic [9:0] PRE_STEP_MA = 10'h03C;
	localparam logic [12:0] VREG_OFFSET_MV = 13'h0F08;
	localparam logic [12:0] VREG_STEP_MV = 13'h0020;
	localparam logic [5:0] TOPOFF_STEP_MIN = 6'h0F;
	localparam logic [7:0] RECHG_LOW_MV = 8'h64;
	localparam logic [7:0] RECHG_HIGH_MV = 8'hC8;

	// Settings presented to the charger core.
	typedef struct packed {
		logic hiz_enable;
		logic status_pin_enable;
		logic [4:0] input_current_limit;
		logic [11:0] input_current_limit_ma;
		logic pulse_frequency_disable;
		logic reverse_boost_enable;
		logic charge_enable_bit;
		logic charging_active;
		logic [2:0] minimum_system_voltage;
		logic boost_battery_low_threshold;
		logic boost_current_limit;
		logic [5:0] fast_charge_current;
		logic [11:0] fast_charge_current_ma;
		logic [3:0] precharge_current;
		logic [9:0] precharge_current_ma;
		logic [3:0] termination_current;
		logic [9:0] termination_current_ma;
		logic [4:0] charge_voltage_code;
		logic [12:0] charge_voltage_mv;
		logic [1:0] top_off_timer;
		logic [5:0] top_off_minutes;
		logic [7:0] recharge_offset_mv;
	} ccr_cfg_t;

endpackage

// [verification/ccr_regs_chk.sv]
`timescale 1ns/100ps
// Watches the register port, the reset events and the decoded settings.
module ccr_regs_chk
	import ccr_pkg::*;
(
	// Clock and reset.
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// Register port.
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic [7:0] O_REG_RDATA,
	input wire logic O_REG_ACK,
	// Events and settings.
	input wire logic I_REG_RESET,
	input wire logic I_WDT_EXPIRED,
	input wire logic I_INPUT_PLUGIN,
	input wire logic [1:0] I_CHARGE_VOLTAGE_TRIM,
	input wire ccr_cfg_t O_CFG,
	input wire logic O_WATCHDOG_KICK
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	// Any reset event outranks a write in the same cycle, so such cycles are left out.
	logic ev;
	logic kw;
	logic [7:0] wd_q;
	assign ev = I_REG_RESET | I_WDT_EXPIRED | I_INPUT_PLUGIN;
	assign kw = I_REG_WR && I_REG_ADDR == ADDR_OPERATION_CONTROL && I_REG_WDATA[POS_KICK] && !I_REG_RESET;
	// Write data bus of the previous cycle, taken every cycle, so that fields of it can be compared a cycle later.
	always_ff @(posedge I_CLK_SYS)
	begin
		wd_q <= I_REG_WDATA;
	end
	sequence kick_req;
		kw;
	endsequence
	sequence cfg_write(logic [7:0] a);
		I_REG_WR && I_REG_ADDR == a && !ev;
	endsequence
	ack_decode_a: assert property (O_REG_ACK == ((I_REG_WR || I_REG_RD) && I_REG_ADDR <= ADDR_LAST))
		else $error("ack does not follow the strobe and offset");
	kick_pulse_a: assert property (kick_req |=> O_WATCHDOG_KICK)
		else $error("kick pulse missing after kick write");
	kick_cause_a: assert property (O_WATCHDOG_KICK |-> $past(kw))
		else $error("kick pulse without a kick write");
	plug_hiz_a: assert property (I_INPUT_PLUGIN && !I_REG_RESET |=> !O_CFG.hiz_enable)
		else $error("plug-in left high impedance set");
	wdt_restore_a: assert property (I_WDT_EXPIRED && !I_REG_RESET |=> O_CFG.charge_enable_bit && !O_CFG.reverse_boost_enable)
		else $error("watchdog did not restore enables");
	icc_clamp_a: assert property (cfg_write(ADDR_FAST_CHARGE_CURRENT) and I_REG_WDATA[5:0] > ICC_MAX_CODE |=> O_CFG.fast_charge_current == ICC_MAX_CODE)
		else $error("fast charge code not clamped");
	icc_zero_a: assert property (O_CFG.fast_charge_current == 6'h00 |-> !O_CFG.charging_active)
		else $error("charging active with zero current code");
	stat_write_a: assert property (cfg_write(ADDR_INPUT_CONTROL) |=> O_CFG.status_pin_enable == (wd_q[6:5] == STAT_PIN_ON) && O_CFG.input_current_limit == wd_q[4:0])
		else $error("input control write not decoded");
	unmapped_read_a: assert property (I_REG_RD && I_REG_ADDR > ADDR_LAST |=> O_REG_RDATA == 8'h00)
		else $error("unmapped read returned data");
endmodule
bind ccr_charger_config_regs ccr_regs_chk chk_i (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_REG_WR(I_REG_WR),
	.I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
	.O_REG_ACK(O_REG_ACK), .I_REG_RESET(I_REG_RESET), .I_WDT_EXPIRED(I_WDT_EXPIRED), .I_INPUT_PLUGIN(I_INPUT_PLUGIN),
	.I_CHARGE_VOLTAGE_TRIM(I_CHARGE_VOLTAGE_TRIM), .O_CFG(O_CFG), .O_WATCHDOG_KICK(O_WATCHDOG_KICK));

// [verification/ccr_host_model.sv]
`timescale 1ns/100ps
// Host side of the register port: one strobe per byte; idle lines carry inverted junk.
module ccr_host_model
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_ack,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial
	begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'hFF;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic k);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		k = i_ack;
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
	endtask
	// Read data is registered, so it is taken once the edge that took the strobe has settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic k);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		k = i_ack;
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule

// [verification/ccr_charger_config_regs_test.sv]
`timescale 1ns/100ps
module ccr_charger_config_regs_test
	import ccr_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_reset = 1'b0, wdt = 1'b0, plug = 1'b0;
	logic [1:0] trim = 2'h0;
	logic wr, rd, ack, kick, k;
	logic [7:0] addr, wdata, rdata, d, v, a;
	logic [5:0] c;
	ccr_cfg_t cfg;
	int n_mismatch = 0, checks_done = 0;
	integer seed = 32'hbce8965b;
	localparam logic [7:0] POR [5] = '{8'h04, 8'h1A, 8'hA2, 8'h22, 8'h58};
	always #5 clk = ~clk;
	ccr_charger_config_regs dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
		.I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_ACK(ack), .I_REG_RESET(reg_reset), .I_WDT_EXPIRED(wdt),
		.I_INPUT_PLUGIN(plug), .I_CHARGE_VOLTAGE_TRIM(trim), .O_CFG(cfg), .O_WATCHDOG_KICK(kick));
	ccr_host_model host (.i_clk(clk), .i_rdata(rdata), .i_ack(ack), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One-edge event pulse: 0 plug-in, 1 watchdog, 2 register reset.
	task pulse(input int s);
		@(posedge clk);
		{reg_reset, wdt, plug} <= 3'h1 << s;
		@(posedge clk);
		{reg_reset, wdt, plug} <= 3'h0;
		#1;
	endtask
	// Writes, then reads back; kick and reserved bits never stick.
	task wr_chk(input logic [7:0] ad, input logic [7:0] x);
		host.wr(ad, x, k);
		chk(k, 1'b1);
		host.rd(ad, d, k);
		chk(d, (ad == 8'h01 || ad == 8'h02) ? x & 8'hBF : x);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			host.rd(i[7:0], d, k);
			chk(d, POR[i]);
		end
		chk(cfg.charge_voltage_mv, 16'h1068);
		chk(cfg.fast_charge_current_ma, 16'h07F8);
		chk({cfg.hiz_enable, cfg.charging_active}, 16'h0001);
		host.rd(8'h05, d, k);
		chk({k, d}, 16'h0000);
		$display("defaults test done");
		repeat (30)
		begin
			v = $random(seed);
			a = {$random(seed)} % 5;
			trim <= v[1:0];
			wr_chk(a, v);
			c = (v[5:0] > 6'h32) ? 6'h32 : v[5:0];
			case (a)
				8'h00: chk(cfg.input_current_limit_ma, 16'h0064 + 16'h0064 * v[4:0]);
				8'h01: chk({cfg.pulse_frequency_disable, cfg.reverse_boost_enable}, {v[7], v[5]});
				8'h02: chk(cfg.fast_charge_current_ma, 16'h003C * c);
				8'h03: chk(cfg.precharge_current_ma, 16'h003C + 16'h003C * v[7:4]);
				default: chk(cfg.charge_voltage_mv, 16'h0F08 + 16'h0020 * v[7:3] + 16'h0008 * trim);
			endcase
			// Each field is compared on its own so no concatenation is cut to the compare width.
			if (a == 8'h03)
				chk(cfg.termination_current_ma, 16'h003C + 16'h003C * v[3:0]);
			if (a == 8'h04)
				chk(cfg.top_off_minutes, 16'h000F * v[2:1]);
			if (a == 8'h04)
				chk(cfg.recharge_offset_mv, v[0] ? 16'h00C8 : 16'h0064);
		end
		$display("random test done");
		wr_chk(8'h02, 8'hFF);
		chk(cfg.fast_charge_current, 6'h32);
		wr_chk(8'h02, 8'h00);
		chk(cfg.charging_active, 1'b0);
		wr_chk(8'h00, 8'hFF);
		pulse(0);
		host.rd(8'h00, d, k);
		chk(d, 8'h7F);
		wr_chk(8'h01, 8'hFF);
		pulse(1);
		host.rd(8'h01, d, k);
		chk(d, 8'h9F);
		host.rd(8'h02, d, k);
		chk(d, 8'hA2);
		wr_chk(8'h04, 8'h07);
		pulse(2);
		host.rd(8'h04, d, k);
		chk(d, 8'h58);
		$display("corner test done");
		wrap_up;
	end
	// The tests need well under 1000 cycles.
	initial
	begin
		#50000;
		n_mismatch++;
		wrap_up;
	end
endmodule
